// File: core/axi_error_response_slave.sv
// default target answering undecoded axi3 accesses with decode error, with violation logs
`timescale 1ns/1ps
module axi_error_response_slave (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// write address channel
	input wire logic [axi_decerr_pkg::ID_WIDTH-1:0] awid,
	input wire logic [axi_decerr_pkg::ADDR_WIDTH-1:0] awaddr,
	input wire logic [3:0] awlen,
	input wire logic [2:0] awsize,
	input wire logic [1:0] awburst,
	input wire logic awvalid,
	output logic awready,
	// write data channel
	input wire logic [axi_decerr_pkg::ID_WIDTH-1:0] wid,
	input wire logic [axi_decerr_pkg::DATA_WIDTH-1:0] wdata,
	input wire logic [axi_decerr_pkg::DATA_WIDTH/8-1:0] wstrb,
	input wire logic wlast,
	input wire logic wvalid,
	output logic wready,
	// write response channel
	output logic [axi_decerr_pkg::ID_WIDTH-1:0] bid,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// read address channel
	input wire logic [axi_decerr_pkg::ID_WIDTH-1:0] arid,
	input wire logic [axi_decerr_pkg::ADDR_WIDTH-1:0] araddr,
	input wire logic [3:0] arlen,
	input wire logic [2:0] arsize,
	input wire logic [1:0] arburst,
	input wire logic arvalid,
	output logic arready,
	// read data channel
	output logic [axi_decerr_pkg::ID_WIDTH-1:0] rid,
	output logic [axi_decerr_pkg::DATA_WIDTH-1:0] rdata,
	output logic [1:0] rresp,
	output logic rlast,
	output logic rvalid,
	input wire logic rready,
	// debug register port
	input wire logic [axi_decerr_pkg::CSR_ADDR_WIDTH-1:0] csr_address,
	input wire logic csr_read,
	input wire logic csr_write,
	input wire logic [31:0] csr_writedata,
	output logic [31:0] csr_readdata,
	// violation interrupt
	output logic irq
);
	// one write log entry holds id, address, first beat and burst info at the configured widths
	localparam int WLOG_WIDTH = axi_decerr_pkg::ID_WIDTH + axi_decerr_pkg::ADDR_WIDTH +
		axi_decerr_pkg::DATA_WIDTH + axi_decerr_pkg::INFO_WIDTH;

	typedef enum logic [1:0] {
		W_IDLE = 2'b00,
		W_DATA = 2'b01,
		W_RESP = 2'b10
	} wr_state_t;

	typedef struct packed {
		wr_state_t wstate;
		logic awready;
		logic wready;
		logic bvalid;
		logic [axi_decerr_pkg::ID_WIDTH-1:0] bid;
		logic first_beat;
		logic [axi_decerr_pkg::ID_WIDTH-1:0] log_id;
		logic [axi_decerr_pkg::ADDR_WIDTH-1:0] log_addr;
		logic [axi_decerr_pkg::DATA_WIDTH-1:0] log_data;
		logic [axi_decerr_pkg::INFO_WIDTH-1:0] log_info;
		logic wlog_push;
		logic [3:0] status;
		logic irq;
		logic [31:0] readdata;
	} top_regs_t;

	top_regs_t s;
	top_regs_t n;

	// read channel and log wiring
	logic rd_violation;
	logic [axi_decerr_pkg::INFO_WIDTH-1:0] rd_info;
	logic rlog_full;
	logic rlog_empty;
	logic rlog_pop;
	logic [axi_decerr_pkg::INFO_WIDTH-1:0] rlog_head;
	logic wlog_full;
	logic wlog_empty;
	logic wlog_pop;
	logic [WLOG_WIDTH-1:0] wlog_entry;
	logic [WLOG_WIDTH-1:0] wlog_head;

	// fields of the write log head, widened to the register layout
	logic [axi_decerr_pkg::ID_WIDTH-1:0] head_id;
	logic [axi_decerr_pkg::ADDR_WIDTH-1:0] head_addr;
	logic [axi_decerr_pkg::DATA_WIDTH-1:0] head_data;
	logic [axi_decerr_pkg::INFO_WIDTH-1:0] head_info;
	logic [63:0] head_addr_ext;
	logic [127:0] head_data_ext;

	// register access decode
	logic status_wr;
	logic [3:0] clear_mask;
	logic [3:0] set_mask;

	// the read side lives in its own responder so it never waits on the write side
	decerr_read_channel u_read (
		.clk(clk),
		.rst_n(rst_n),
		.arid(arid),
		.arlen(arlen),
		.arsize(arsize),
		.arburst(arburst),
		.arvalid(arvalid),
		.arready(arready),
		.rid(rid),
		.rlast(rlast),
		.rvalid(rvalid),
		.rready(rready),
		.violation(rd_violation),
		.violation_info(rd_info)
	);

	// read violation log, burst info only
	error_log_fifo #(
		.WIDTH(axi_decerr_pkg::INFO_WIDTH),
		.DEPTH(axi_decerr_pkg::LOG_DEPTH)
	) u_read_log (
		.clk(clk),
		.rst_n(rst_n),
		.push(rd_violation && axi_decerr_pkg::CSR_ENABLE),
		.push_data(rd_info),
		.full(rlog_full),
		.pop(rlog_pop),
		.empty(rlog_empty),
		.head(rlog_head)
	);

	// write violation log: id, address, first data beat and burst info
	error_log_fifo #(
		.WIDTH(WLOG_WIDTH),
		.DEPTH(axi_decerr_pkg::LOG_DEPTH)
	) u_write_log (
		.clk(clk),
		.rst_n(rst_n),
		.push(s.wlog_push && axi_decerr_pkg::CSR_ENABLE),
		.push_data(wlog_entry),
		.full(wlog_full),
		.pop(wlog_pop),
		.empty(wlog_empty),
		.head(wlog_head)
	);

	// read data never carries meaning; every beat answers decode error
	assign rdata = '0;
	assign rresp = axi_decerr_pkg::RESP_DECERR;
	assign bresp = axi_decerr_pkg::RESP_DECERR;

	// pack the entry captured by the write state machine
	assign wlog_entry = {s.log_id, s.log_addr, s.log_data, s.log_info};
	assign {head_id, head_addr, head_data, head_info} = wlog_head;
	assign head_addr_ext = 64'(head_addr);
	assign head_data_ext = 128'(head_data);

	// reading the last meaningful data word, or the top word, retires the write entry
	assign wlog_pop = csr_read && !wlog_empty &&
		((csr_address == axi_decerr_pkg::WLOG_POP_OFFSET) ||
		(csr_address == axi_decerr_pkg::OFF_WLOG_DATA3));
	// reading the read log info word retires the read entry
	assign rlog_pop = csr_read && !rlog_empty && (csr_address == axi_decerr_pkg::OFF_RLOG_INFO);

	// status write-one-clear decode and hardware set events
	assign status_wr = csr_write && (csr_address == axi_decerr_pkg::OFF_STATUS);
	assign clear_mask = status_wr ? csr_writedata[3:0] : 4'h0;
	always_comb
	begin
		set_mask = 4'h0;
		if (axi_decerr_pkg::CSR_ENABLE)
		begin
			set_mask[axi_decerr_pkg::STAT_RD_VIOL] = rd_violation;
			set_mask[axi_decerr_pkg::STAT_WR_VIOL] = s.wlog_push;
			set_mask[axi_decerr_pkg::STAT_RD_OVF] = rd_violation && rlog_full;
			set_mask[axi_decerr_pkg::STAT_WR_OVF] = s.wlog_push && wlog_full;
		end
	end

	// write state machine, status bits and the registered read mux
	always_comb
	begin
		n = s;
		n.wlog_push = 1'b0;
		unique case (s.wstate)
			W_IDLE:
			begin
				// one address at a time; data is taken only after it
				if (awvalid)
				begin
					n.awready = 1'b0;
					n.wready = 1'b1;
					n.bid = awid;
					n.first_beat = 1'b1;
					n.log_id = awid;
					n.log_addr = awaddr;
					n.log_info = {awburst, awlen, awsize};
					n.wstate = W_DATA;
				end
			end
			W_DATA:
			begin
				// beats of the accepted burst are drained until wlast; wid is not checked
				if (wvalid)
				begin
					n.first_beat = 1'b0;
					if (s.first_beat)
						n.log_data = wdata;
					if (wlast)
					begin
						n.wready = 1'b0;
						n.bvalid = 1'b1;
						n.wlog_push = 1'b1;
						n.wstate = W_RESP;
					end
				end
			end
			W_RESP:
			begin
				if (bready)
				begin
					n.bvalid = 1'b0;
					n.awready = 1'b1;
					n.wstate = W_IDLE;
				end
			end
			default:
			begin
				n.awready = 1'b1;
				n.wready = 1'b0;
				n.bvalid = 1'b0;
				n.wstate = W_IDLE;
			end
		endcase

		// sticky bits: a set in the same cycle as a clear wins; fifo pops never clear them
		n.status = (s.status & ~clear_mask) | set_mask;
		n.irq = n.status[axi_decerr_pkg::STAT_RD_VIOL] || n.status[axi_decerr_pkg::STAT_WR_VIOL];

		// read data registered here gives the fixed one-cycle latency
		n.readdata = 32'h0000_0000;
		if (csr_read)
		begin
			unique case (csr_address)
				axi_decerr_pkg::OFF_STATUS:
					n.readdata = 32'(s.status);
				axi_decerr_pkg::OFF_RLOG_INFO:
					n.readdata = 32'(rlog_head) << axi_decerr_pkg::INFO_LSB;
				axi_decerr_pkg::OFF_WLOG_INFO:
					n.readdata = 32'(head_info) << axi_decerr_pkg::INFO_LSB;
				axi_decerr_pkg::OFF_WLOG_ID:
					n.readdata = 32'(head_id);
				axi_decerr_pkg::OFF_WLOG_ADDR_LO:
					n.readdata = head_addr_ext[31:0];
				axi_decerr_pkg::OFF_WLOG_ADDR_HI:
					n.readdata = head_addr_ext[63:32];
				axi_decerr_pkg::OFF_WLOG_DATA0:
					n.readdata = head_data_ext[31:0];
				axi_decerr_pkg::OFF_WLOG_DATA1:
					n.readdata = head_data_ext[63:32];
				axi_decerr_pkg::OFF_WLOG_DATA2:
					n.readdata = head_data_ext[95:64];
				axi_decerr_pkg::OFF_WLOG_DATA3:
					n.readdata = head_data_ext[127:96];
				default:
					n.readdata = 32'h0000_0000;
			endcase
		end
	end

	// single register stage for all top-level state; pops free slots for new entries
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s <= '0;
			s.wstate <= W_IDLE;
			s.awready <= 1'b1;
			s.status <= axi_decerr_pkg::STATUS_RESET;
		end
		else
			s <= n;
	end

	// outputs straight from the register stage
	assign awready = s.awready;
	assign wready = s.wready;
	assign bvalid = s.bvalid;
	assign bid = s.bid;
	assign csr_readdata = s.readdata;
	assign irq = s.irq;
endmodule // axi_error_response_slave

// File: shared/axi_decerr_pkg.sv
// shared constants for the decode-error default target and its debug register port
package axi_decerr_pkg;
	// configured widths and log depth
	localparam int ID_WIDTH = 4;
	localparam int ADDR_WIDTH = 32;
	localparam int DATA_WIDTH = 32;
	localparam int LOG_DEPTH = 4;
	localparam int INFO_WIDTH = 9;
	localparam int CSR_ADDR_WIDTH = 10;
	localparam logic CSR_ENABLE = 1'h1;
	// axi response code
	localparam logic [1:0] RESP_DECERR = 2'h3;
	// register byte offsets
	localparam logic [9:0] OFF_STATUS = 10'h000;
	localparam logic [9:0] OFF_RLOG_INFO = 10'h100;
	localparam logic [9:0] OFF_WLOG_INFO = 10'h190;
	localparam logic [9:0] OFF_WLOG_ID = 10'h194;
	localparam logic [9:0] OFF_WLOG_ADDR_LO = 10'h198;
	localparam logic [9:0] OFF_WLOG_ADDR_HI = 10'h19C;
	localparam logic [9:0] OFF_WLOG_DATA0 = 10'h1A0;
	localparam logic [9:0] OFF_WLOG_DATA1 = 10'h1A4;
	localparam logic [9:0] OFF_WLOG_DATA2 = 10'h1A8;
	localparam logic [9:0] OFF_WLOG_DATA3 = 10'h1AC;
	// highest meaningful data word, whose read pops the write log
	localparam logic [9:0] WLOG_POP_OFFSET = (DATA_WIDTH == 32) ? OFF_WLOG_DATA0 :
		(DATA_WIDTH == 64) ? OFF_WLOG_DATA1 : OFF_WLOG_DATA3;
	// status bit positions and reset value
	localparam int STAT_WR_VIOL = 0;
	localparam int STAT_RD_VIOL = 1;
	localparam int STAT_WR_OVF = 2;
	localparam int STAT_RD_OVF = 3;
	localparam logic [3:0] STATUS_RESET = 4'h0;
	// burst info word: size at 6:4, length at 10:7, type at 12:11
	localparam int INFO_LSB = 4;
endpackage

// File: core/error_log_fifo.sv
// small log memory with registered head word, used for both violation logs
`timescale 1ns/1ps
module error_log_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 4
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// fill side
	input wire logic push,
	input wire logic [WIDTH-1:0] push_data,
	output logic full,
	// drain side
	input wire logic pop,
	output logic empty,
	output logic [WIDTH-1:0] head
);
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [3:0] wr_ptr;
		logic [3:0] rd_ptr;
		logic [4:0] count;
		logic [WIDTH-1:0] head;
	} fifo_state_t;

	fifo_state_t s;
	fifo_state_t n;
	logic do_push;
	logic do_pop;
	logic [3:0] rd_next;

	// a push into a full log is dropped; the caller flags the overflow
	always_comb
	begin
		n = s;
		do_push = push && (s.count != 5'(DEPTH));
		do_pop = pop && (s.count != 5'h00);
		rd_next = s.rd_ptr;
		if (do_pop)
			rd_next = (s.rd_ptr == 4'(DEPTH - 1)) ? 4'h0 : s.rd_ptr + 4'h1;
		if (do_push)
		begin
			n.mem[s.wr_ptr] = push_data;
			n.wr_ptr = (s.wr_ptr == 4'(DEPTH - 1)) ? 4'h0 : s.wr_ptr + 4'h1;
		end
		n.rd_ptr = rd_next;
		if (do_push && !do_pop)
			n.count = s.count + 5'h01;
		else if (do_pop && !do_push)
			n.count = s.count - 5'h01;
		// bypass so a word written into the head slot shows at once
		n.head = (do_push && (s.wr_ptr == rd_next)) ? push_data : s.mem[rd_next];
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			s <= '0;
		else
			s <= n;
	end

	assign full = (s.count == 5'(DEPTH));
	assign empty = (s.count == 5'h00);
	assign head = s.head;
endmodule // error_log_fifo

// File: core/decerr_read_channel.sv
// read side responder: takes one read burst at a time and answers each beat with decode error
`timescale 1ns/1ps
module decerr_read_channel (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// read address channel
	input wire logic [axi_decerr_pkg::ID_WIDTH-1:0] arid,
	input wire logic [3:0] arlen,
	input wire logic [2:0] arsize,
	input wire logic [1:0] arburst,
	input wire logic arvalid,
	output logic arready,
	// read data channel
	output logic [axi_decerr_pkg::ID_WIDTH-1:0] rid,
	output logic rlast,
	output logic rvalid,
	input wire logic rready,
	// violation event toward the log
	output logic violation,
	output logic [axi_decerr_pkg::INFO_WIDTH-1:0] violation_info
);
	typedef enum logic {
		R_IDLE = 1'b0,
		R_BURST = 1'b1
	} rd_state_t;

	typedef struct packed {
		rd_state_t state;
		logic arready;
		logic rvalid;
		logic rlast;
		logic [axi_decerr_pkg::ID_WIDTH-1:0] rid;
		logic [3:0] beats_left;
		logic violation;
		logic [axi_decerr_pkg::INFO_WIDTH-1:0] info;
	} rd_regs_t;

	rd_regs_t s;
	rd_regs_t n;

	// arready drops while a burst is answered, so only one read is outstanding
	always_comb
	begin
		n = s;
		n.violation = 1'b0;
		unique case (s.state)
			R_IDLE:
			begin
				if (arvalid)
				begin
					n.arready = 1'b0;
					n.rvalid = 1'b1;
					n.rid = arid;
					n.beats_left = arlen;
					n.rlast = (arlen == 4'h0);
					n.violation = 1'b1;
					n.info = {arburst, arlen, arsize};
					n.state = R_BURST;
				end
			end
			R_BURST:
			begin
				if (rready)
				begin
					if (s.rlast)
					begin
						n.rvalid = 1'b0;
						n.rlast = 1'b0;
						n.arready = 1'b1;
						n.state = R_IDLE;
					end
					else
					begin
						n.beats_left = s.beats_left - 4'h1;
						n.rlast = (s.beats_left == 4'h1);
					end
				end
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s <= '0;
			s.arready <= 1'b1;
		end
		else
			s <= n;
	end

	assign arready = s.arready;
	assign rid = s.rid;
	assign rlast = s.rlast;
	assign rvalid = s.rvalid;
	assign violation = s.violation;
	assign violation_info = s.info;
endmodule // decerr_read_channel

// File: tb/decerr_monitor.sv
// port-level assertions for the decode-error default target
`timescale 1ns/1ps
module decerr_monitor (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// write side
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic wlast,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic [1:0] bresp,
	// read side
	input wire logic arvalid,
	input wire logic arready,
	input wire logic [3:0] arlen,
	input wire logic rvalid,
	input wire logic [1:0] rresp,
	input wire logic rlast,
	// debug port and interrupt
	input wire logic csr_read,
	input wire logic [31:0] csr_readdata,
	input wire logic irq
);
	// one domain, so clock and reset are given once
	default clocking mon_cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	// responses: timing, code and hold
	b_after_wlast_a: assert property (wvalid && wready && wlast |=> bvalid)
		else $error("no write response after last beat");
	bresp_decerr_a: assert property (bvalid |-> bresp == axi_decerr_pkg::RESP_DECERR)
		else $error("write response not decode error");
	rresp_decerr_a: assert property (rvalid |-> rresp == axi_decerr_pkg::RESP_DECERR)
		else $error("read response not decode error");
	b_holds_a: assert property (bvalid && !bready |=> bvalid)
		else $error("write response dropped early");
	// acceptance of one per direction
	one_write_a: assert property (bvalid |-> !awready && !wready)
		else $error("second write taken while one open");
	one_read_a: assert property (rvalid |-> !arready)
		else $error("second read taken while one open");
	single_beat_a: assert property (arvalid && arready && arlen == 4'h0 |=> rvalid && rlast)
		else $error("single read beat not last");
	// debug port answers only the cycle after a read
	csr_idle_zero_a: assert property (!csr_read |=> csr_readdata == 32'h0)
		else $error("read data without a read");
	// every violation raises the interrupt one cycle on
	irq_raised_a: assert property ($rose(bvalid) || $rose(rvalid) |=> irq)
		else $error("violation without interrupt");
endmodule // decerr_monitor

bind axi_error_response_slave decerr_monitor i_mon (.clk, .rst_n, .awvalid, .awready, .wvalid, .wready,
	.wlast, .bvalid, .bready, .bresp, .arvalid, .arready, .arlen, .rvalid, .rresp, .rlast, .csr_read,
	.csr_readdata, .irq);

// File: tb/axi_master_model.sv
// behavioural axi3 master whose undecoded accesses reach the target
`timescale 1ns/1ps
module axi_master_model (
	// clock
	input wire logic clk,
	// write address and data
	output logic [3:0] awid,
	output logic [31:0] awaddr,
	output logic [3:0] awlen,
	output logic [2:0] awsize,
	output logic [1:0] awburst,
	output logic awvalid,
	input wire logic awready,
	output logic [3:0] wid,
	output logic [31:0] wdata,
	output logic [3:0] wstrb,
	output logic wlast,
	output logic wvalid,
	input wire logic wready,
	// write response
	input wire logic [3:0] bid,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	output logic bready,
	// read
	output logic [3:0] arid,
	output logic [31:0] araddr,
	output logic [3:0] arlen,
	output logic [2:0] arsize,
	output logic [1:0] arburst,
	output logic arvalid,
	input wire logic arready,
	input wire logic [3:0] rid,
	input wire logic [1:0] rresp,
	input wire logic rlast,
	input wire logic rvalid,
	output logic rready
);
	// idle at time zero
	initial
	begin
		{awid, awaddr, awlen, awsize, awburst, awvalid, wid, wdata, wstrb, wlast, wvalid, bready} = '0;
		{arid, araddr, arlen, arsize, arburst, arvalid, rready} = '0;
	end
	// write: address, then beats, response taken after st stall cycles
	task automatic wr(input logic [3:0] id, input logic [31:0] a, input logic [3:0] len,
		input logic [31:0] d, input int st, output logic [3:0] rsp_id, output logic [1:0] rsp);
		awid <= id;
		wid <= id;
		awaddr <= a;
		awlen <= len;
		awsize <= 3'h2;
		awburst <= 2'h1;
		awvalid <= 1'b1;
		do @(posedge clk); while (awready !== 1'b1);
		awvalid <= 1'b0;
		awaddr <= ~a;
		// data only after the address, never interleaved
		for (int i = 0; i <= len; i++)
		begin
			wdata <= d + i;
			wstrb <= 4'hF;
			wlast <= (i == len);
			wvalid <= 1'b1;
			do @(posedge clk); while (wready !== 1'b1);
		end
		wvalid <= 1'b0;
		wlast <= 1'b0;
		wdata <= ~d;
		repeat (st) @(posedge clk);
		bready <= 1'b1;
		do @(posedge clk); while (bvalid !== 1'b1);
		rsp_id = bid;
		rsp = bresp;
		bready <= 1'b0;
	endtask
	// read: ready drops between beats, so one edge always passes before it rises again
	task automatic rd(input logic [3:0] id, input logic [3:0] len, input logic [2:0] sz, input logic [1:0] bt,
		input int st, output int nb, output logic [3:0] rsp_id, output logic [1:0] rsp);
		arid <= id;
		araddr <= 32'hF000_0000;
		arlen <= len;
		arsize <= sz;
		arburst <= bt;
		arvalid <= 1'b1;
		do @(posedge clk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		araddr <= 32'h0FFF_FFFF;
		nb = 0;
		rsp = 2'h3;
		do
		begin
			repeat (st + 1) @(posedge clk);
			rready <= 1'b1;
			do @(posedge clk); while (rvalid !== 1'b1);
			rready <= 1'b0;
			nb++;
			rsp &= rresp;
			rsp_id = rid;
		end
		while (rlast !== 1'b1 && nb < 20);
	endtask
endmodule // axi_master_model

// File: tb/axi_error_response_slave_bench.sv
// self-checking bench for the decode-error default target
`timescale 1ns/1ps
module axi_error_response_slave_bench;
	// design ports
	logic clk, rst_n, awvalid, awready, wlast, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rlast, rvalid, rready, csr_read, csr_write, irq;
	logic [3:0] awid, wid, bid, arid, rid, awlen, arlen, wstrb, got_id, got_id2;
	logic [31:0] awaddr, araddr, wdata, csr_writedata, csr_readdata, rdata;
	logic [2:0] awsize, arsize;
	logic [1:0] awburst, arburst, bresp, rresp, got_rsp, got_rsp2;
	logic [9:0] csr_address;
	logic [9:0] offs[10] = '{10'h000, 10'h100, 10'h190, 10'h194, 10'h198, 10'h19C, 10'h1A0, 10'h1A4,
		10'h1A8, 10'h1AC};
	int err_total, n_checks, cyc, nb;

	axi_error_response_slave i_dut (.clk, .rst_n, .awid, .awaddr, .awlen, .awsize, .awburst, .awvalid,
		.awready, .wid, .wdata, .wstrb, .wlast, .wvalid, .wready, .bid, .bresp, .bvalid, .bready, .arid,
		.araddr, .arlen, .arsize, .arburst, .arvalid, .arready, .rid, .rdata(rdata), .rresp, .rlast, .rvalid,
		.rready, .csr_address, .csr_read, .csr_write, .csr_writedata, .csr_readdata, .irq);
	axi_master_model i_master (.clk, .awid, .awaddr, .awlen, .awsize, .awburst, .awvalid, .awready, .wid,
		.wdata, .wstrb, .wlast, .wvalid, .wready, .bid, .bresp, .bvalid, .bready, .arid, .araddr, .arlen,
		.arsize, .arburst, .arvalid, .arready, .rid, .rresp, .rlast, .rvalid, .rready);

	// 125 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// hang guard; the whole sequence needs well under two thousand cycles
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			err_total++;
			final_report();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	// debug read: data is taken the cycle after the strobe
	task automatic csr_rd(input logic [9:0] a, input logic [31:0] exp);
		csr_address <= a;
		csr_read <= 1'b1;
		@(posedge clk);
		csr_read <= 1'b0;
		@(posedge clk);
		chk(csr_readdata, exp);
	endtask
	task automatic csr_wr(input logic [9:0] a, input logic [31:0] d);
		csr_address <= a;
		csr_writedata <= d;
		csr_write <= 1'b1;
		@(posedge clk);
		csr_write <= 1'b0;
		@(posedge clk);
	endtask
	function automatic logic [31:0] info(input logic [1:0] bt, input logic [3:0] len, input logic [2:0] sz);
		return {19'h0, bt, len, sz, 4'h0};
	endfunction
	task automatic final_report();
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	initial
	begin
		rst_n = 1'b0;
		{csr_address, csr_read, csr_write, csr_writedata} = '0;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		// reset values, unmapped space reads zero
		foreach (offs[i]) csr_rd(offs[i], 32'h0);
		csr_rd(10'h3FC, 32'h0);
		$display("test reset done");
		// three-beat write: only the first beat is logged
		i_master.wr(4'hA, 32'h1234_5678, 4'h2, 32'hCAFE_F00D, 3, got_id, got_rsp);
		chk({28'h0, got_id}, 32'hA);
		chk({30'h0, got_rsp}, 32'h3);
		csr_rd(10'h000, 32'h1);
		chk({31'h0, irq}, 32'h1);
		csr_rd(10'h190, info(2'h1, 4'h2, 3'h2));
		csr_rd(10'h194, 32'hA);
		csr_rd(10'h198, 32'h1234_5678);
		csr_rd(10'h19C, 32'h0);
		csr_rd(10'h1A4, 32'h0);
		csr_rd(10'h1A8, 32'h0);
		csr_rd(10'h1A0, 32'hCAFE_F00D);
		csr_rd(10'h000, 32'h1);
		csr_wr(10'h000, 32'h0);
		csr_rd(10'h000, 32'h1);
		csr_wr(10'h000, 32'h1);
		csr_rd(10'h000, 32'h0);
		chk({31'h0, irq}, 32'h0);
		$display("test write log done");
		// every burst type with growing length and size, slower ready each time
		for (int k = 0; k < 3; k++)
		begin
			i_master.rd(4'h5, k[3:0] + 4'h1, k[2:0], k[1:0], k, nb, got_id, got_rsp);
			chk(nb, k + 2);
			chk({28'h0, got_id}, 32'h5);
			chk({30'h0, got_rsp}, 32'h3);
			csr_rd(10'h100, info(k[1:0], k[3:0] + 4'h1, k[2:0]));
		end
		csr_rd(10'h000, 32'h2);
		chk(rdata, 32'h0);
		csr_wr(10'h000, 32'h2);
		$display("test read log done");
		// one more violation each way than the log holds, back to back
		for (int k = 0; k <= axi_decerr_pkg::LOG_DEPTH; k++)
			i_master.wr(k[3:0], 32'h100 * k, 4'h0, 32'h5000 + k, 0, got_id, got_rsp);
		for (int k = 0; k <= axi_decerr_pkg::LOG_DEPTH; k++)
			i_master.rd(4'h1, 4'h0, 3'h2, 2'h1, 0, nb, got_id, got_rsp);
		csr_rd(10'h000, 32'hF);
		for (int k = 0; k < axi_decerr_pkg::LOG_DEPTH; k++)
			csr_rd(10'h1A0, 32'h5000 + k);
		for (int k = 0; k < axi_decerr_pkg::LOG_DEPTH; k++)
			csr_rd(10'h100, info(2'h1, 4'h0, 3'h2));
		csr_wr(10'h000, 32'hF);
		csr_rd(10'h000, 32'h0);
		$display("test overflow done");
		// drained log takes new entries; read and write together both complete
		fork
			i_master.wr(4'h3, 32'h4444_0000, 4'h0, 32'h7777_0001, 1, got_id, got_rsp);
			i_master.rd(4'h6, 4'h1, 3'h2, 2'h1, 2, nb, got_id2, got_rsp2);
		join
		chk({30'h0, got_rsp}, 32'h3);
		chk({30'h0, got_rsp2}, 32'h3);
		chk({28'h0, got_id}, 32'h3);
		chk({28'h0, got_id2}, 32'h6);
		csr_rd(10'h000, 32'h3);
		csr_rd(10'h1A0, 32'h7777_0001);
		// two more entries: the top data word retires the older one, so the newer becomes the head
		i_master.wr(4'h4, 32'h55AA_0000, 4'h0, 32'h1357_9BDF, 0, got_id, got_rsp);
		i_master.wr(4'h9, 32'h66BB_0000, 4'h0, 32'h2468_ACE0, 0, got_id, got_rsp);
		csr_rd(10'h1AC, 32'h0);
		csr_rd(10'h194, 32'h9);
		csr_rd(10'h1A0, 32'h2468_ACE0);
		$display("test concurrent done");
		final_report();
	end
endmodule // axi_error_response_slave_bench
